// ===== sct_pkg.sv
// package of constants and types for the speculation check table block
package sct_pkg;
  localparam int SCT_NREG = 128;
  localparam int SCT_REGW = 7;
  localparam int SCT_AW = 64;
  localparam int SCT_ENTRIES = 8;
  localparam int SCT_TYPEW = 2;
  localparam int SCT_SIZEW = 4;
  // collection register index field within the address
  localparam int SCT_COLL_LSB = 3;
  localparam int SCT_COLL_MSB = 8;
  localparam logic [63:0] SCT_COLL_RST = 64'h0;
  localparam logic [SCT_REGW-1:0] SCT_REG_RST = 7'h00;
  // register map, word offsets as byte addresses
  localparam logic [7:0] SCT_OFF_CTRL = 8'h00;
  localparam logic [7:0] SCT_OFF_STATUS = 8'h04;
  localparam logic [7:0] SCT_OFF_COLL_LO = 8'h08;
  localparam logic [7:0] SCT_OFF_COLL_HI = 8'h0c;
  localparam logic [7:0] SCT_OFF_COUNT = 8'h10;
  localparam logic [31:0] SCT_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] SCT_BAD_READ = 32'hdead_beef;
  // fp deferred token encoding: exponent all ones-minus-one, zero mantissa
  localparam logic [81:0] SCT_FP_TOKEN = {1'b0, 17'h1fffe, 64'h0};
  typedef enum logic [3:0] {
    SCT_OP_NONE = 4'h0,
    SCT_OP_ADV_LOAD = 4'h1,
    SCT_OP_CHECK_RELOAD = 4'h2,
    SCT_OP_CHECK_BRANCH = 4'h3,
    SCT_OP_SPEC_LOAD = 4'h4,
    SCT_OP_COMBINED_LOAD = 4'h5,
    SCT_OP_STORE = 4'h6,
    SCT_OP_GR_SPILL = 4'h7,
    SCT_OP_GR_FILL = 4'h8,
    SCT_OP_SPEC_CHECK = 4'h9,
    SCT_OP_ALU = 4'ha,
    SCT_OP_TOKEN_TEST = 4'hb,
    SCT_OP_FP_CLASS = 4'hc,
    SCT_OP_FP_SPILL = 4'hd,
    SCT_OP_FP_FILL = 4'he
  } sct_op_t;
endpackage

// ===== sct_tab_if.sv
// interface carrying table commands between the core and the address table
`timescale 1ns/1ps
interface sct_tab_if;
  import sct_pkg::*;
  logic alloc;
  logic [SCT_REGW-1:0] alloc_reg;
  logic [SCT_AW-1:0] alloc_addr;
  logic [SCT_TYPEW-1:0] alloc_type;
  logic [SCT_SIZEW-1:0] alloc_size;
  logic look;
  logic [SCT_REGW-1:0] look_reg;
  logic [SCT_TYPEW-1:0] look_type;
  logic hit;
  logic store;
  logic [SCT_AW-1:0] store_addr;
  logic [SCT_SIZEW-1:0] store_size;
  logic flush;
  logic [7:0] valid_count;
  modport core (output alloc, alloc_reg, alloc_addr, alloc_type, alloc_size, look,
    look_reg, look_type, store, store_addr, store_size, flush, input hit, valid_count);
  modport table_side (input alloc, alloc_reg, alloc_addr, alloc_type, alloc_size, look,
    look_reg, look_type, store, store_addr, store_size, flush, output hit, valid_count);
endinterface

// ===== sct_addr_table.sv
// speculative address table: allocation, lookup and store invalidation
`timescale 1ns/1ps
module sct_addr_table #(
  parameter int ENTRIES = sct_pkg::SCT_ENTRIES
) (
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset
  input wire logic clk_en, // freezes state when low
  sct_tab_if.table_side tab // table commands
);
  import sct_pkg::*;
  typedef struct packed {
    logic [ENTRIES-1:0] valid;
    logic [ENTRIES-1:0][SCT_REGW-1:0] regn;
    logic [ENTRIES-1:0][SCT_AW-1:0] addr;
    logic [ENTRIES-1:0][SCT_TYPEW-1:0] ltype;
    logic [ENTRIES-1:0][SCT_SIZEW-1:0] lsize;
    logic [$clog2(ENTRIES)-1:0] victim;
  } sct_tab_state_t;
  sct_tab_state_t st, next_st;
  logic [SCT_AW:0] s_end, e_end;
  // lookup is combinational: match register and type
  always_comb begin
    tab.hit = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (st.valid[i] && st.regn[i] == tab.look_reg && st.ltype[i] == tab.look_type) begin
        tab.hit = tab.look;
      end
    end
  end
  // entry count for the count register
  always_comb begin
    tab.valid_count = 8'h00;
    for (int i = 0; i < ENTRIES; i++) begin
      tab.valid_count = tab.valid_count + {7'h00, st.valid[i]};
    end
  end
  // next state: invalidate, then allocate
  always_comb begin
    next_st = st;
    s_end = '0;
    e_end = '0;
    if (tab.flush) begin
      next_st.valid = '0;
    end
    if (tab.store) begin
      s_end = {1'b0, tab.store_addr} + {{(SCT_AW-SCT_SIZEW+1){1'b0}}, tab.store_size};
      for (int i = 0; i < ENTRIES; i++) begin
        e_end = {1'b0, st.addr[i]} + {{(SCT_AW-SCT_SIZEW+1){1'b0}}, st.lsize[i]};
        if ({1'b0, tab.store_addr} < e_end && {1'b0, st.addr[i]} < s_end) begin
          next_st.valid[i] = 1'b0;
        end
      end
    end
    if (tab.alloc) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (st.regn[i] == tab.alloc_reg) begin
          next_st.valid[i] = 1'b0;
        end
      end
      // victim slot replaced round robin on every allocation, full or not
      next_st.valid[st.victim] = 1'b1;
      next_st.regn[st.victim] = tab.alloc_reg;
      next_st.addr[st.victim] = tab.alloc_addr;
      next_st.ltype[st.victim] = tab.alloc_type;
      next_st.lsize[st.victim] = tab.alloc_size;
      next_st.victim = st.victim + 1'b1;
    end
  end
  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  // ==========================================================
  // checks
  property p_alloc_hits;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && tab.alloc && !tab.store && !tab.flush) |=> (tab.valid_count != 8'h00);
  endproperty
  a_alloc_hits: assert property (p_alloc_hits) else $error("alloc left table empty");
  property p_flush_empty;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && tab.flush && !tab.alloc) |=> (tab.valid_count == 8'h00);
  endproperty
  a_flush_empty: assert property (p_flush_empty) else $error("flush left entries");
  c_alloc: cover property (@(posedge ref_clk) tab.alloc ##1 tab.look && tab.hit);
endmodule

// ===== sct_token_coll.sv
// spill token collection register with spill write and fill read
`timescale 1ns/1ps
module sct_token_coll (
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset
  input wire logic clk_en, // freezes state when low
  input wire logic spill, // spill strobe
  input wire logic [5:0] idx, // address bits 8:3
  input wire logic spill_tok, // token being spilled
  input wire logic sw_we, // software write
  input wire logic [63:0] sw_data, // software data
  output logic fill_tok, // token read for fill
  output logic [63:0] coll // register contents
);
  import sct_pkg::*;
  typedef struct packed {
    logic [63:0] bits;
  } sct_coll_state_t;
  sct_coll_state_t st, next_st;
  // software load first, spill overrides its bit
  always_comb begin
    next_st = st;
    if (sw_we) begin
      next_st.bits = sw_data;
    end
    if (spill) begin
      next_st.bits[idx] = spill_tok;
    end
  end
  assign fill_tok = st.bits[idx];
  assign coll = st.bits;
  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{bits: SCT_COLL_RST};
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  property p_spill_bit;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && spill) |=> (coll[$past(idx)] == $past(spill_tok));
  endproperty
  a_spill_bit: assert property (p_spill_bit) else $error("spill bit not stored");
endmodule

// ===== sct_spec_core.sv
// speculation check core: token bits, checks, spill/fill and register bus
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sct_spec_core (
  input wire logic ref_clk, // core clock 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic clk_en, // freezes all state when low
  input wire logic op_valid, // operation issued this cycle
  input sct_pkg::sct_op_t op, // operation code
  input wire logic [sct_pkg::SCT_REGW-1:0] dst, // destination physical register
  input wire logic [sct_pkg::SCT_REGW-1:0] dst2, // second destination
  input wire logic dst2_en, // second destination present
  input wire logic [sct_pkg::SCT_REGW-1:0] src1, // first source register
  input wire logic [sct_pkg::SCT_REGW-1:0] src2, // second source register
  input wire logic src2_en, // second source used
  input wire logic spec, // operation is speculative
  input wire logic [63:0] addr, // memory address
  input wire logic [sct_pkg::SCT_TYPEW-1:0] ld_type, // load type
  input wire logic [sct_pkg::SCT_SIZEW-1:0] ld_size, // access size in bytes
  input wire logic mem_fault, // load hit an exception
  input wire logic fault_deferrable, // exception is deferrable by policy
  input wire logic [63:0] pc, // address of the current op
  input wire logic [63:0] rec_offset, // relative recovery offset
  input wire logic [81:0] fp_val, // fp register value for class/spill
  output logic redirect, // branch to recovery
  output logic [63:0] redirect_pc, // recovery target
  output logic reissue, // reissue load into dst
  output logic consume_fault, // token consumption fault
  output logic test_result, // token test / fp class result
  output logic spill_tok_out, // token stored alongside spill data
  output logic fill_tok_in, // token restored by fill
  output logic fp_token_out, // fp load result is the token value
  input wire logic [7:0] avs_address, // bus byte address
  input wire logic avs_read, // bus read
  input wire logic avs_write, // bus write
  input wire logic [31:0] avs_writedata, // bus write data
  input wire logic [3:0] avs_byteenable, // bus byte lanes
  output logic [31:0] avs_readdata, // bus read data
  output logic avs_waitrequest // bus stall
);
  import sct_pkg::*;
  // ==========================================================
  // state
  typedef struct packed {
    logic [SCT_NREG-1:0] tok;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic ack;
    logic [15:0] fault_count;
    logic redirect;
    logic [63:0] redirect_pc;
    logic reissue;
    logic consume_fault;
    logic test_result;
    logic spill_tok;
    logic fill_tok;
    logic fp_token;
  } sct_core_state_t;
  sct_core_state_t st, next_st;
  sct_tab_if tab ();
  logic coll_we;
  logic [63:0] coll_wdata;
  logic [63:0] coll;
  logic fill_bit;
  logic src_tok;
  logic deferred;
  logic is_load;
  logic [31:0] reg_rd;
  // ==========================================================
  // sub blocks
  sct_addr_table #(.ENTRIES(SCT_ENTRIES)) u_table (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .tab(tab)
  );
  sct_token_coll u_coll (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .spill(op_valid && op == SCT_OP_GR_SPILL),
    .idx(addr[SCT_COLL_MSB:SCT_COLL_LSB]),
    .spill_tok(st.tok[src1]),
    .sw_we(coll_we),
    .sw_data(coll_wdata),
    .fill_tok(fill_bit),
    .coll(coll)
  );
  // ==========================================================
  // decode helpers
  always_comb begin
    src_tok = st.tok[src1] | (src2_en & st.tok[src2]);
    is_load = op == SCT_OP_SPEC_LOAD || op == SCT_OP_COMBINED_LOAD;
    deferred = is_load && mem_fault && fault_deferrable && st.ctrl[0];
  end
  // table commands
  always_comb begin
    tab.alloc = op_valid && (op == SCT_OP_ADV_LOAD ||
      (op == SCT_OP_COMBINED_LOAD && !deferred));
    tab.alloc_reg = dst;
    tab.alloc_addr = addr;
    tab.alloc_type = ld_type;
    tab.alloc_size = ld_size;
    tab.look = op_valid && (op == SCT_OP_CHECK_RELOAD || op == SCT_OP_CHECK_BRANCH);
    tab.look_reg = (op == SCT_OP_CHECK_BRANCH) ? src1 : dst;
    tab.look_type = ld_type;
    tab.store = op_valid && (op == SCT_OP_STORE || op == SCT_OP_GR_SPILL ||
      op == SCT_OP_FP_SPILL);
    tab.store_addr = addr;
    tab.store_size = ld_size;
    tab.flush = avs_write && !st.ack && avs_address == SCT_OFF_CTRL &&
      avs_byteenable[0] && avs_writedata[1];
  end
  // ==========================================================
  // operation handling and register bus
  always_comb begin
    next_st = st;
    next_st.redirect = 1'b0;
    next_st.reissue = 1'b0;
    next_st.consume_fault = 1'b0;
    next_st.ack = 1'b0;
    next_st.fp_token = 1'b0;
    coll_we = 1'b0;
    coll_wdata = coll;
    if (op_valid) begin
      unique case (op)
        SCT_OP_CHECK_BRANCH: begin
          if (!tab.hit) begin
            next_st.redirect = 1'b1;
            next_st.redirect_pc = pc + rec_offset;
          end
        end
        SCT_OP_CHECK_RELOAD: begin
          next_st.reissue = !tab.hit;
          if (!tab.hit) begin
            next_st.tok[dst] = 1'b0;
          end
        end
        SCT_OP_SPEC_CHECK: begin
          if (st.tok[src1]) begin
            next_st.redirect = 1'b1;
            next_st.redirect_pc = pc + rec_offset;
          end
        end
        SCT_OP_SPEC_LOAD, SCT_OP_COMBINED_LOAD: begin
          next_st.tok[dst] = deferred;
          next_st.consume_fault = mem_fault && !deferred;
        end
        SCT_OP_ADV_LOAD: begin
          next_st.tok[dst] = 1'b0;
        end
        SCT_OP_GR_SPILL: begin
          next_st.spill_tok = st.tok[src1];
        end
        SCT_OP_GR_FILL: begin
          next_st.tok[dst] = fill_bit;
          next_st.fill_tok = fill_bit;
        end
        SCT_OP_TOKEN_TEST: begin
          next_st.test_result = st.tok[src1];
        end
        SCT_OP_FP_CLASS: begin
          next_st.test_result = fp_val == SCT_FP_TOKEN;
        end
        SCT_OP_FP_SPILL, SCT_OP_FP_FILL: begin
          next_st.fp_token = fp_val == SCT_FP_TOKEN;
        end
        SCT_OP_ALU: begin
          if (spec) begin
            next_st.tok[dst] = src_tok;
            if (dst2_en) begin
              next_st.tok[dst2] = src_tok;
            end
          end else begin
            next_st.consume_fault = src_tok;
            next_st.tok[dst] = 1'b0;
            if (dst2_en) begin
              next_st.tok[dst2] = 1'b0;
            end
          end
        end
        SCT_OP_STORE, SCT_OP_NONE: begin
          next_st.consume_fault = !spec && st.tok[src1] && op == SCT_OP_STORE;
        end
        default: begin
          next_st.consume_fault = 1'b0;
        end
      endcase
      if (deferred && is_load) begin
        next_st.fp_token = 1'b1;
      end
    end
    if (next_st.consume_fault) begin
      next_st.fault_count = st.fault_count + 16'h0001;
    end
    // register read decode
    unique case (avs_address)
      SCT_OFF_CTRL: reg_rd = st.ctrl;
      SCT_OFF_STATUS: reg_rd = {16'h0000, st.fault_count};
      SCT_OFF_COLL_LO: reg_rd = coll[31:0];
      SCT_OFF_COLL_HI: reg_rd = coll[63:32];
      SCT_OFF_COUNT: reg_rd = {24'h000000, tab.valid_count};
      default: reg_rd = SCT_BAD_READ;
    endcase
    // bus access takes one wait cycle
    if ((avs_read || avs_write) && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = reg_rd;
      if (avs_write) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            if (avs_address == SCT_OFF_CTRL) begin
              next_st.ctrl[8*b +: 8] = avs_writedata[8*b +: 8];
            end
            if (avs_address == SCT_OFF_COLL_LO) begin
              coll_wdata[8*b +: 8] = avs_writedata[8*b +: 8];
            end
            if (avs_address == SCT_OFF_COLL_HI) begin
              coll_wdata[32+8*b +: 8] = avs_writedata[8*b +: 8];
            end
          end
        end
        next_st.ctrl[1] = 1'b0;
        coll_we = avs_address == SCT_OFF_COLL_LO || avs_address == SCT_OFF_COLL_HI;
      end
    end
  end
  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= SCT_CTRL_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  // outputs
  assign redirect = st.redirect;
  assign redirect_pc = st.redirect_pc;
  assign reissue = st.reissue;
  assign consume_fault = st.consume_fault;
  assign test_result = st.test_result;
  assign spill_tok_out = st.spill_tok;
  assign fill_tok_in = st.fill_tok;
  assign fp_token_out = st.fp_token;
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  // ==========================================================
  // checks
  property p_branch_miss;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_CHECK_BRANCH && !tab.hit) |=>
        (redirect && redirect_pc == $past(pc) + $past(rec_offset));
  endproperty
  a_branch_miss: assert property (p_branch_miss) else $error("check miss no branch");
  property p_branch_hit;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_CHECK_BRANCH && tab.hit) |=> !redirect;
  endproperty
  a_branch_hit: assert property (p_branch_hit) else $error("check hit branched");
  property p_reload_miss;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_CHECK_RELOAD && !tab.hit) |=> (reissue && !redirect);
  endproperty
  a_reload_miss: assert property (p_reload_miss) else $error("check load no reissue");
  property p_propagate;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_ALU && spec && src_tok) |=> st.tok[$past(dst)];
  endproperty
  a_propagate: assert property (p_propagate) else $error("token not propagated");
  property p_consume;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_ALU && !spec && src_tok) |=> consume_fault;
  endproperty
  a_consume: assert property (p_consume) else $error("no consumption fault");
  property p_spec_check;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_SPEC_CHECK && st.tok[src1]) |=> redirect;
  endproperty
  a_spec_check: assert property (p_spec_check) else $error("spec check no branch");
  property p_defer;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_COMBINED_LOAD && deferred) |-> !tab.alloc;
  endproperty
  a_defer: assert property (p_defer) else $error("tokened load allocated");
  property p_fill;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && op_valid && op == SCT_OP_GR_FILL) |=> (st.tok[$past(dst)] == $past(fill_bit));
  endproperty
  a_fill: assert property (p_fill) else $error("fill token wrong");
  property p_bus;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && avs_read && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait too long");
  c_redirect: cover property (@(posedge ref_clk) redirect);
  c_reissue: cover property (@(posedge ref_clk) reissue);
  c_fault: cover property (@(posedge ref_clk) consume_fault);
endmodule

// ===== sct_issue_model.sv
// issue-side partner model counting recoveries and reloads
`timescale 1ns/1ps
module sct_issue_model (
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset
  input wire logic redirect, // recovery branch pulse
  input wire logic reissue, // reload request pulse
  output logic [7:0] n_redir, // recoveries taken
  output logic [7:0] n_reload // reloads served
);
  // count each one-cycle pulse from the core
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      n_redir <= 8'h00;
      n_reload <= 8'h00;
    end else begin
      n_redir <= n_redir + {7'h00, redirect};
      n_reload <= n_reload + {7'h00, reissue};
    end
  end
endmodule

// ===== speculation_check_table_and_token_bits_test.sv
// self-checking bench for the speculation check core
`timescale 1ns/1ps
module speculation_check_table_and_token_bits_test;
  import sct_pkg::*;
  logic ref_clk, rst, op_valid, spec, mem_fault, dst2_en, src2_en, avs_read, avs_write;
  sct_op_t op;
  logic [SCT_REGW-1:0] dst, dst2, src1, src2;
  logic [63:0] addr, pc, rdp;
  logic [1:0] ld_type;
  logic [7:0] avs_address, n_redir, n_reload;
  logic [31:0] avs_writedata, avs_readdata;
  logic redirect, reissue, cfault, tres, stok, ftok, fptk, avs_waitrequest;
  logic [81:0] fpv;
  int error_cnt = 0;
  int num_checks = 0;
  localparam logic [63:0] A = 64'h100;
  localparam logic [63:0] OFS = 64'h40;
  // ====================
  // design and partner
  sct_spec_core u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .op_valid(op_valid),
    .op(op), .dst(dst), .dst2(dst2), .dst2_en(dst2_en), .src1(src1), .src2(src2),
    .src2_en(src2_en), .spec(spec), .addr(addr), .ld_type(ld_type), .ld_size(4'h8),
    .mem_fault(mem_fault), .fault_deferrable(1'b1), .pc(pc), .rec_offset(OFS),
    .fp_val(fpv), .redirect(redirect), .redirect_pc(rdp), .reissue(reissue),
    .consume_fault(cfault), .test_result(tres), .spill_tok_out(stok), .fill_tok_in(ftok),
    .fp_token_out(fptk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  sct_issue_model u_model (.ref_clk(ref_clk), .rst(rst), .redirect(redirect),
    .reissue(reissue), .n_redir(n_redir), .n_reload(n_reload));
  // ====================
  // tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // issue one op, sample its registered answer
  task automatic do_op(input sct_op_t o, input logic [6:0] d, input logic [6:0] s,
      input logic sp, input logic [63:0] a, input logic [1:0] ty, input logic f);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op <= o;
    dst <= d;
    dst2 <= d + 7'h01;
    dst2_en <= (o == SCT_OP_ALU);
    src1 <= s;
    src2 <= s;
    src2_en <= sp;
    spec <= sp;
    addr <= a;
    ld_type <= ty;
    mem_fault <= f;
    pc <= pc + 64'h10;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    mem_fault <= 1'b0;
    @(negedge ref_clk);
  endtask
  // avalon access, request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // avalon read, data taken at the completing edge, then released
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp("readdata", {32'h0, e}, {32'h0, avs_readdata});
    avs_read <= 1'b0;
  endtask
  // avalon write, released at the completing edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    avs_write <= 1'b0;
  endtask
  // ====================
  // clock, watchdog, sequence
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    {rst, op_valid, spec, mem_fault, dst2_en, src2_en, avs_read, avs_write} = 8'hff;
    {op_valid, spec, mem_fault, dst2_en, src2_en, avs_read, avs_write} = 7'h00;
    op = SCT_OP_NONE;
    {dst, dst2, src1, src2, ld_type, avs_address} = '0;
    addr = 64'h0;
    pc = 64'h1000;
    avs_writedata = 32'h0;
    fpv = SCT_FP_TOKEN;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(SCT_OFF_CTRL, SCT_CTRL_RST);
    rd(SCT_OFF_COUNT, 32'h0);
    rd(8'h40, SCT_BAD_READ);
    $display("test registers done");
    do_op(SCT_OP_ADV_LOAD, 7'h05, 7'h00, 1'b0, A, 2'h1, 1'b0);
    do_op(SCT_OP_CHECK_BRANCH, 7'h00, 7'h05, 1'b0, A, 2'h1, 1'b0);
    cmp("redirect", 64'h0, {63'h0, redirect});
    do_op(SCT_OP_STORE, 7'h00, 7'h00, 1'b0, A + 64'h4, 2'h0, 1'b0);
    do_op(SCT_OP_CHECK_BRANCH, 7'h00, 7'h05, 1'b0, A, 2'h1, 1'b0);
    cmp("redirect", 64'h1, {63'h0, redirect});
    cmp("redirect_pc", pc + OFS, rdp);
    do_op(SCT_OP_ADV_LOAD, 7'h05, 7'h00, 1'b0, A, 2'h1, 1'b0);
    do_op(SCT_OP_STORE, 7'h00, 7'h00, 1'b0, A + 64'h8, 2'h0, 1'b0);
    do_op(SCT_OP_CHECK_BRANCH, 7'h00, 7'h05, 1'b0, A, 2'h1, 1'b0);
    cmp("redirect", 64'h0, {63'h0, redirect});
    do_op(SCT_OP_ADV_LOAD, 7'h06, 7'h00, 1'b0, A + 64'h10, 2'h1, 1'b0);
    do_op(SCT_OP_ADV_LOAD, 7'h06, 7'h00, 1'b0, A + 64'h20, 2'h1, 1'b0);
    rd(SCT_OFF_COUNT, 32'h2);
    do_op(SCT_OP_CHECK_RELOAD, 7'h06, 7'h00, 1'b0, A + 64'h20, 2'h2, 1'b0);
    cmp("reissue", 64'h1, {63'h0, reissue});
    cmp("redirect", 64'h0, {63'h0, redirect});
    do_op(SCT_OP_CHECK_RELOAD, 7'h06, 7'h00, 1'b0, A + 64'h20, 2'h1, 1'b0);
    cmp("reissue", 64'h0, {63'h0, reissue});
    $display("test data speculation done");
    do_op(SCT_OP_SPEC_LOAD, 7'h09, 7'h00, 1'b1, A + 64'h80, 2'h0, 1'b1);
    do_op(SCT_OP_TOKEN_TEST, 7'h00, 7'h09, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("test_result", 64'h1, {63'h0, tres});
    do_op(SCT_OP_ALU, 7'h0a, 7'h09, 1'b1, 64'h0, 2'h0, 1'b0);
    do_op(SCT_OP_TOKEN_TEST, 7'h00, 7'h0b, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("test_result", 64'h1, {63'h0, tres});
    do_op(SCT_OP_ALU, 7'h0c, 7'h0a, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("consume_fault", 64'h1, {63'h0, cfault});
    do_op(SCT_OP_SPEC_CHECK, 7'h00, 7'h0a, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("redirect", 64'h1, {63'h0, redirect});
    do_op(SCT_OP_SPEC_CHECK, 7'h00, 7'h03, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("redirect", 64'h0, {63'h0, redirect});
    do_op(SCT_OP_FP_CLASS, 7'h00, 7'h00, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("test_result", 64'h1, {63'h0, tres});
    rd(SCT_OFF_STATUS, 32'h1);
    $display("test control speculation done");
    do_op(SCT_OP_GR_SPILL, 7'h00, 7'h09, 1'b0, 64'h18, 2'h0, 1'b0);
    cmp("spill_tok_out", 64'h1, {63'h0, stok});
    rd(SCT_OFF_COLL_LO, 32'h8);
    do_op(SCT_OP_GR_FILL, 7'h0d, 7'h00, 1'b0, 64'h18, 2'h0, 1'b0);
    cmp("fill_tok_in", 64'h1, {63'h0, ftok});
    do_op(SCT_OP_TOKEN_TEST, 7'h00, 7'h0d, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("test_result", 64'h1, {63'h0, tres});
    do_op(SCT_OP_COMBINED_LOAD, 7'h14, 7'h00, 1'b1, A + 64'h40, 2'h1, 1'b1);
    do_op(SCT_OP_CHECK_BRANCH, 7'h00, 7'h14, 1'b0, A + 64'h40, 2'h1, 1'b0);
    cmp("redirect", 64'h1, {63'h0, redirect});
    @(negedge ref_clk);
    cmp("model_redirects", 64'h3, {56'h0, n_redir});
    cmp("model_reloads", 64'h1, {56'h0, n_reload});
    $display("test spill and combined done");
    do_op(SCT_OP_FP_SPILL, 7'h00, 7'h00, 1'b0, 64'h200, 2'h0, 1'b0);
    cmp("fp_token_out", 64'h1, {63'h0, fptk});
    @(posedge ref_clk);
    fpv <= 82'h0;
    do_op(SCT_OP_FP_CLASS, 7'h00, 7'h00, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("test_result", 64'h0, {63'h0, tres});
    wr(SCT_OFF_COLL_HI, 32'h8000_0000);
    rd(SCT_OFF_COLL_HI, 32'h8000_0000);
    rd(SCT_OFF_COLL_LO, 32'h8);
    do_op(SCT_OP_GR_FILL, 7'h0e, 7'h00, 1'b0, 64'h10, 2'h0, 1'b0);
    cmp("fill_tok_in", 64'h0, {63'h0, ftok});
    do_op(SCT_OP_GR_FILL, 7'h0e, 7'h00, 1'b0, 64'h1f8, 2'h0, 1'b0);
    cmp("fill_tok_in", 64'h1, {63'h0, ftok});
    do_op(SCT_OP_TOKEN_TEST, 7'h00, 7'h0e, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("test_result", 64'h1, {63'h0, tres});
    wr(SCT_OFF_CTRL, 32'h0);
    do_op(SCT_OP_SPEC_LOAD, 7'h0f, 7'h00, 1'b1, A + 64'h90, 2'h0, 1'b1);
    do_op(SCT_OP_TOKEN_TEST, 7'h00, 7'h0f, 1'b0, 64'h0, 2'h0, 1'b0);
    cmp("test_result", 64'h0, {63'h0, tres});
    wr(SCT_OFF_CTRL, 32'h2);
    rd(SCT_OFF_COUNT, 32'h0);
    rd(SCT_OFF_CTRL, 32'h0);
    $display("test bus writes done");
    stop_test();
  end
endmodule
